// *** rtl/lpf_pkg.sv ***
`default_nettype none
package lpf_pkg;
   // -------------------------------
   // commands, receiver, config
   // -------------------------------
   typedef enum logic [1:0] {
      LPF_CMD_PWM  = 2'h0,
      LPF_CMD_TRIM = 2'h1,
      LPF_CMD_GLOB = 2'h2,
      LPF_CMD_CFG  = 2'h3
   } lpf_cmd_e_t;
   // gray along idle -> shift -> full
   typedef enum logic [1:0] {
      RX_IDLE  = 2'h0,
      RX_SHIFT = 2'h1,
      RX_FULL  = 2'h3
   } lpf_rx_e_t;
   typedef struct packed {
      logic quarter_global_mode;
      logic pwm_on;
      logic crst;
      logic watchdog_enable_bit;
      logic mux;
   } lpf_cfg_t;
   // -------------------------------
   // state records
   // -------------------------------
   typedef struct packed {
      logic        prev;
      logic [23:0] cnt;
      logic        trip;
   } lpf_wd_t;
   typedef struct packed {
      lpf_rx_e_t         rx;
      lpf_cmd_e_t        cmd;
      logic [3:0]        vbit;
      logic [4:0]        vidx;
      logic [15:0]       sh;
      logic [31:0][13:0] mid;
      logic [31:0][13:0] act;
      logic [7:0]        trim_y;
      logic [7:0]        trim_z;
      logic [7:0]        glob_mid;
      logic [7:0]        glob_act;
      lpf_cfg_t          cfg;
      logic [13:0]       pwm;
      logic [6:0]        sf;
      logic              otemp;
      logic              wd_flag;
      logic [15:0]       drive;
      logic              an_a_n;
      logic              an_b_n;
      logic [9:0]        tally;
      logic              tally_vld;
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
   } lpf_state_t;
endpackage
`default_nettype wire

// *** rtl/lpf_pwm_chan.sv ***
`default_nettype none
// one output comparator; odd outputs run mirrored to spread supply load
module lpf_pwm_chan #(
   parameter int         W   = 12,
   parameter bit         INV = 1'b0
) (
   input  wire logic [13:0] i_cnt,
   input  wire logic [13:0] i_val,
   input  wire logic [13:0] i_off,
   output logic             o_on
);
   localparam logic [13:0] LAST = 14'((1 << W) - 1);
   logic [13:0] pos;
   logic [14:0] stop;
   // ---------------------------------
   // window [off, off+val) clipped at end
   // ---------------------------------
   always_comb begin
      pos  = INV ? LAST - i_cnt : i_cnt;
      stop = {1'b0, i_off} + {1'b0, i_val};
      o_on = (pos >= i_off) && ({1'b0, pos} < stop) && (pos <= LAST - i_off);
   end
endmodule
`default_nettype wire

// *** rtl/lpf_regs.svh ***
`ifndef LPF_REGS_SVH
`define LPF_REGS_SVH
// ---------------------------------------------
// frame and subframe timing, in clock periods
// ---------------------------------------------
`define LPF_FRAME_CLKS     524288
`define LPF_SUB_CLKS_12    4096
`define LPF_SUB_CLKS_14    16384
`define LPF_USE_CLKS_12    4064
`define LPF_USE_CLKS_14    16320
`define LPF_SUBFRAMES_14   32
`define LPF_VAL_W          14
// ---------------------------------------------
// watchdog: time in ms, cycles derived at 4 ns
// ---------------------------------------------
`define LPF_CLK_PERIOD_NS  4
`define LPF_WATCHDOG_ENABLE_BIT_TIME_MS   40
`define LPF_WATCHDOG_ENABLE_BIT_CYCLES    ((`LPF_WATCHDOG_ENABLE_BIT_TIME_MS * 1000000) / `LPF_CLK_PERIOD_NS)
// ---------------------------------------------
// data lengths per device
// ---------------------------------------------
`define LPF_SHORT_BITS     16
`define LPF_VALS_DIRECT    16
`define LPF_VALS_MUX       32
// ---------------------------------------------
// register byte offsets and fields
// ---------------------------------------------
`define LPF_OFS_CFG        8'h00
`define LPF_OFS_STATUS     8'h04
`define LPF_OFS_TRIM       8'h08
`define LPF_OFS_GLOBAL     8'h0C
`define LPF_CFG_W          5
`define LPF_ST_OTEMP       0
`define LPF_ST_WATCHDOG_ENABLE_BIT        1
`define LPF_ST_OPEN        2
`define LPF_ST_SF_LSB      8
`endif

// *** rtl/lpf_top.sv ***
// What this block does
// - 14-bit subframe is 16384 clocks; 32 subframes make a 524288-clock frame.
// - usable on-time is 4064 of 4096 or 16320 of 16384 clocks.
// - config bit 0 set enables multiplex; anode switches alternate, active low.
// - in multiplex, ports drive alternate value sets; global subframes halve.
// - enabled watchdog clears all pwm latches if an input stays still 40ms.
// - watchdog leaves trim, global, counters and multiplex setting alone.
// - any open output below 200mV adds at most one to tally.
// - overtemperature forces all outputs off until it falls below lower threshold.
// - command being received picks which fault kind is tallied.
// - trim, global and config commands carry exactly sixteen bits each.
// - every data byte arrives most significant bit first.
// - pwm command carries 192, 384, 224 or 448 bits by variant and mode.
// - pwm values go to an intermediate latch, applied at subframe and clock zero.
// - two 8-bit trim values, z first, applied at once.
// - global byte sent twice, right aligned, applied at subframe and clock zero.
// - global value n lights n+1 of the subframes, spread evenly.
// - four commands by two-bit code; each device gets its own data.
// - command pair sent three times in the header.
// - command low bit zero counts overtemperature, one counts open outputs.
// - watchdog runs only while config bit 1 is set; default clear.
// - 12-bit outputs are off first 16 and last 16 clocks of each subframe.
//
// Design decisions made here: the placing of the registers and the APB slave port.
`include "lpf_regs.svh"
`default_nettype none
module lpf_top #(
   parameter int PWM_BITS    = 12,
   parameter int WATCHDOG_ENABLE_BIT_CYCLES = `LPF_WATCHDOG_ENABLE_BIT_CYCLES
) (
   input  wire logic              I_CLK,
   input  wire logic              I_RST,
   // apb slave
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [7:0]        PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic                   PREADY,
   output logic [31:0]            PRDATA,
   output logic                   PSLVERR,
   // data segment from the header parser
   input  wire logic              I_SEG_START,
   input  wire lpf_pkg::lpf_cmd_e_t I_CMD_CODE,
   input  wire logic              I_DATA_VALID,
   input  wire logic              I_DATA_BIT,
   // fault tally field passing through
   input  wire logic              I_TALLY_VALID,
   input  wire logic [9:0]        I_TALLY_IN,
   output logic                   O_TALLY_VALID,
   output logic [9:0]             O_TALLY_OUT,
   // raw serial inputs seen by the watchdog
   input  wire logic              I_SERIAL_CLOCK_IN,
   input  wire logic              I_SERIAL_DATA_IN,
   input  wire logic              I_FRAME_LOAD_IN,
   // analog comparators
   input  wire logic [15:0]       I_OPEN_LED,
   input  wire logic              I_TEMP_ABOVE_HI,
   input  wire logic              I_TEMP_BELOW_LO,
   // driver side
   output logic [15:0]            O_DRIVE,
   output logic                   O_ANODE_SWITCH_A_N,
   output logic                   O_ANODE_SWITCH_B_N,
   output logic [7:0]             O_PORT_CURRENT_TRIM_Y,
   output logic [7:0]             O_PORT_CURRENT_TRIM_Z
);
   import lpf_pkg::*;

   // ---------------------------------------------
   // variant geometry
   // ---------------------------------------------
   localparam int SUB  = 1 << PWM_BITS;
   localparam int USE  = (PWM_BITS == 12) ? `LPF_USE_CLKS_12 : `LPF_USE_CLKS_14;
   localparam int SF_W = 19 - PWM_BITS;
   localparam logic [13:0] SUB_LAST = 14'(SUB - 1);
   localparam logic [13:0] OFF      = 14'((SUB - USE) / 2);
   localparam logic [13:0] VMASK    = 14'(SUB - 1);
   localparam logic [6:0]  SF_LAST  = 7'((1 << SF_W) - 1);
   localparam logic [3:0]  VLAST    = 4'(PWM_BITS - 1);
   localparam logic [3:0]  SLAST    = 4'(`LPF_SHORT_BITS - 1);
   localparam logic [4:0]  NV_DIR   = 5'(`LPF_VALS_DIRECT - 1);
   localparam logic [4:0]  NV_MUX   = 5'(`LPF_VALS_MUX - 1);

   lpf_state_t s_reg;
   lpf_state_t s_next;
   logic [2:0]  wd_hit;
   logic        wd_trip;
   logic [15:0] chan_on;
   logic        sel_b;
   logic        glob_on;
   logic        zero_pt;
   logic        fault;
   logic        apb_go;
   logic        apb_done;
   logic [6:0]  sf_wrap;

   // ---------------------------------------------
   // watchdogs, one per monitored input
   // ---------------------------------------------
   lpf_watchdog_enable_bit #(.CYCLES(WATCHDOG_ENABLE_BIT_CYCLES)) u_wd_clk (
      .i_clk  (I_CLK),
      .i_rst  (I_RST),
      .i_en   (s_reg.cfg.watchdog_enable_bit),
      .i_lvl  (I_SERIAL_CLOCK_IN),
      .o_trip (wd_hit[0])
   );
   lpf_watchdog_enable_bit #(.CYCLES(WATCHDOG_ENABLE_BIT_CYCLES)) u_wd_dat (
      .i_clk  (I_CLK),
      .i_rst  (I_RST),
      .i_en   (s_reg.cfg.watchdog_enable_bit),
      .i_lvl  (I_SERIAL_DATA_IN),
      .o_trip (wd_hit[1])
   );
   lpf_watchdog_enable_bit #(.CYCLES(WATCHDOG_ENABLE_BIT_CYCLES)) u_wd_ld (
      .i_clk  (I_CLK),
      .i_rst  (I_RST),
      .i_en   (s_reg.cfg.watchdog_enable_bit),
      .i_lvl  (I_FRAME_LOAD_IN),
      .o_trip (wd_hit[2])
   );
   assign wd_trip = |wd_hit;

   // ---------------------------------------------
   // per-output comparators, odd outputs mirrored
   // ---------------------------------------------
   assign sel_b = s_reg.cfg.mux & s_reg.sf[0];
   for (genvar i = 0; i < 16; i++) begin : g_chan
      lpf_pwm_chan #(.W(PWM_BITS), .INV(i % 2 == 1)) u_chan (
         .i_cnt (s_reg.pwm),
         .i_val (sel_b ? s_reg.act[16 + i] : s_reg.act[i]),
         .i_off (OFF),
         .o_on  (chan_on[i])
      );
   end

   // ---------------------------------------------
   // global density: n+1 of 2^w subframes lit
   // ---------------------------------------------
   function automatic logic glob_lit(input logic [6:0] idx, input logic [7:0] val,
                                     input int unsigned w);
      logic [7:0]  msk;
      logic [8:0]  np1;
      logic [16:0] a;
      logic [16:0] b;
      msk = 8'((9'h001 << w) - 9'h001);
      np1 = {1'b0, val & msk} + 9'h001;
      a   = 17'({8'h00, idx} * np1);
      b   = a + 17'(np1);
      // an edge of floor(k*(n+1)/2^w) marks a lit subframe
      glob_lit = (b >> w) != (a >> w);
   endfunction

   always_comb begin
      int unsigned w;
      logic [6:0]  gi;
      w  = SF_W;
      gi = s_reg.sf;
      if (s_reg.cfg.mux) begin
         w  = w - 1;
         gi = s_reg.sf >> 1;
      end
      if (PWM_BITS == 14 && s_reg.cfg.quarter_global_mode) begin
         w = w - 2;
      end
      glob_on = glob_lit(gi, s_reg.glob_act, w);
   end

   // in 14-bit, quarter mode cuts the subframe wheel to a quarter
   assign sf_wrap = (PWM_BITS == 14 && s_reg.cfg.quarter_global_mode) ? (SF_LAST >> 2) : SF_LAST;
   assign zero_pt = (s_reg.pwm == 14'h0000) && (s_reg.sf == 7'h00);
   // the code being received picks the fault kind
   assign fault   = I_CMD_CODE[0] ? (|I_OPEN_LED) : s_reg.otemp;
   assign apb_go   = PSEL & PENABLE & ~s_reg.pready;
   assign apb_done = PSEL & PENABLE & s_reg.pready;

   // ---------------------------------------------
   // next state
   // ---------------------------------------------
   always_comb begin
      logic [15:0] sh_new;
      logic [4:0]  nv;
      sh_new = {s_reg.sh[14:0], I_DATA_BIT};
      nv     = s_reg.cfg.mux ? NV_MUX : NV_DIR;
      s_next = s_reg;

      // frame counters; crst is a one-shot
      if (s_reg.cfg.crst) begin
         s_next.pwm      = 14'h0000;
         s_next.sf       = 7'h00;
         s_next.cfg.crst = 1'b0;
      end else if (s_reg.pwm == SUB_LAST) begin
         s_next.pwm = 14'h0000;
         s_next.sf  = (s_reg.sf >= sf_wrap) ? 7'h00 : s_reg.sf + 7'h01;
      end else begin
         s_next.pwm = s_reg.pwm + 14'h0001;
      end

      // staged values land only at the frame origin
      if (zero_pt) begin
         s_next.act      = s_reg.mid;
         s_next.glob_act = s_reg.glob_mid;
      end

      // data segment receiver
      if (I_SEG_START) begin
         s_next.rx   = RX_SHIFT;
         s_next.cmd  = I_CMD_CODE;
         s_next.vbit = 4'h0;
         s_next.vidx = 5'h00;
      end else if (s_reg.rx == RX_SHIFT && I_DATA_VALID) begin
         s_next.sh   = sh_new;
         s_next.vbit = s_reg.vbit + 4'h1;
         case (s_reg.cmd)
            LPF_CMD_PWM: begin
               if (s_reg.vbit == VLAST) begin
                  // z7 arrives first; 15-k modulo 32 also maps the second set
                  s_next.mid[5'h0F - s_reg.vidx] = sh_new[13:0] & VMASK;
                  s_next.vbit = 4'h0;
                  s_next.vidx = s_reg.vidx + 5'h01;
                  if (s_reg.vidx == nv) begin
                     s_next.rx = RX_FULL;
                  end
               end
            end
            LPF_CMD_TRIM: begin
               if (s_reg.vbit == SLAST) begin
                  s_next.trim_z = sh_new[15:8];
                  s_next.trim_y = sh_new[7:0];
                  s_next.rx     = RX_FULL;
               end
            end
            LPF_CMD_GLOB: begin
               if (s_reg.vbit == SLAST) begin
                  s_next.glob_mid = sh_new[7:0];
                  s_next.rx       = RX_FULL;
               end
            end
            LPF_CMD_CFG: begin
               if (s_reg.vbit == SLAST) begin
                  s_next.cfg = lpf_cfg_t'(sh_new[`LPF_CFG_W-1:0]);
                  s_next.rx  = RX_FULL;
               end
            end
            default: s_next.rx = RX_IDLE;
         endcase
      end

      // silent link: drop only the pwm values
      if (wd_trip) begin
         s_next.mid     = '0;
         s_next.act     = '0;
         s_next.wd_flag = 1'b1;
      end

      // thermal hysteresis
      if (I_TEMP_ABOVE_HI) begin
         s_next.otemp = 1'b1;
      end else if (I_TEMP_BELOW_LO) begin
         s_next.otemp = 1'b0;
      end

      // tally field passes with at most one added
      s_next.tally_vld = I_TALLY_VALID;
      if (I_TALLY_VALID) begin
         s_next.tally = I_TALLY_IN + {9'h000, fault};
      end

      // outputs, one clock behind the counters
      s_next.drive  = (s_reg.cfg.pwm_on && glob_on && !s_reg.otemp) ? chan_on : 16'h0000;
      s_next.an_a_n = ~(s_reg.cfg.mux & ~s_reg.sf[0]);
      s_next.an_b_n = ~(s_reg.cfg.mux & s_reg.sf[0]);

      // apb: answer on the second access cycle
      s_next.pready  = apb_go;
      s_next.pslverr = 1'b0;
      s_next.prdata  = 32'h00000000;
      if (apb_go) begin
         case (PADDR)
            `LPF_OFS_CFG:    s_next.prdata = {27'h0000000, s_reg.cfg};
            `LPF_OFS_STATUS: s_next.prdata = {17'h00000, s_reg.sf, 5'h00, |I_OPEN_LED,
                                              s_reg.wd_flag, s_reg.otemp};
            `LPF_OFS_TRIM:   s_next.prdata = {16'h0000, s_reg.trim_y, s_reg.trim_z};
            `LPF_OFS_GLOBAL: s_next.prdata = {16'h0000, s_reg.glob_mid, s_reg.glob_act};
            default:         s_next.pslverr = 1'b1;
         endcase
      end
      if (apb_done && PWRITE) begin
         case (PADDR)
            `LPF_OFS_CFG: s_next.cfg = lpf_cfg_t'(PWDATA[`LPF_CFG_W-1:0]);
            `LPF_OFS_STATUS: begin
               // a trip in the same cycle keeps the flag set
               if (PWDATA[`LPF_ST_WATCHDOG_ENABLE_BIT] && !wd_trip) begin
                  s_next.wd_flag = 1'b0;
               end
            end
            default: s_next.wd_flag = s_next.wd_flag;
         endcase
      end
   end

   // ---------------------------------------------
   // state register
   // ---------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         s_reg        <= '0;
         s_reg.an_a_n <= 1'b1;
         s_reg.an_b_n <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign PREADY                = s_reg.pready;
   assign PRDATA                = s_reg.prdata;
   assign PSLVERR               = s_reg.pslverr;
   assign O_TALLY_VALID         = s_reg.tally_vld;
   assign O_TALLY_OUT           = s_reg.tally;
   assign O_DRIVE               = s_reg.drive;
   assign O_ANODE_SWITCH_A_N    = s_reg.an_a_n;
   assign O_ANODE_SWITCH_B_N    = s_reg.an_b_n;
   assign O_PORT_CURRENT_TRIM_Y = s_reg.trim_y;
   assign O_PORT_CURRENT_TRIM_Z = s_reg.trim_z;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   sequence seq_origin;
      zero_pt && !s_reg.cfg.crst && !wd_trip;
   endsequence
   sequence seq_apb_access;
      PSEL && PENABLE && !PREADY;
   endsequence

   AST_SUB_WRAP: assert property (s_reg.pwm == SUB_LAST && !s_reg.cfg.crst |=> s_reg.pwm == 14'h0000)
      else $error("subframe counter did not wrap");
   AST_OFF_ZONE: assert property (s_reg.pwm < OFF |=> O_DRIVE == 16'h0000)
      else $error("output lit in leading off zone");
   AST_MUX_ANODE: assert property (s_reg.cfg.mux |=> O_ANODE_SWITCH_A_N != O_ANODE_SWITCH_B_N)
      else $error("anode switches not alternating");
   AST_WATCHDOG_ENABLE_BIT_CLEAR: assert property (wd_trip |=> s_reg.act == '0 && s_reg.mid == '0)
      else $error("watchdog did not clear pwm latches");
   AST_WATCHDOG_ENABLE_BIT_KEEP: assert property (wd_trip && !I_SEG_START && s_reg.rx != RX_SHIFT
                                   |=> $stable(s_reg.trim_y) && $stable(s_reg.cfg.mux))
      else $error("watchdog disturbed kept settings");
   AST_WATCHDOG_ENABLE_BIT_OFF: assert property (!s_reg.cfg.watchdog_enable_bit |=> !wd_trip)
      else $error("watchdog fired while disabled");
   AST_OTEMP: assert property (s_reg.otemp |=> O_DRIVE == 16'h0000)
      else $error("output lit during overtemperature");
   AST_TALLY: assert property (I_TALLY_VALID |=> O_TALLY_VALID
                               && O_TALLY_OUT == $past(I_TALLY_IN) + {9'h000, $past(fault)})
      else $error("tally field wrong");
   AST_LOAD_ORIGIN: assert property (seq_origin |=> s_reg.act == $past(s_reg.mid))
      else $error("pwm values not applied at origin");
   AST_APB_ONE: assert property (seq_apb_access |=> PREADY ##1 !PREADY)
      else $error("pready not a single cycle");
endmodule
`default_nettype wire

// *** rtl/lpf_watchdog_enable_bit.sv ***
`default_nettype none
// toggle watchdog for one serial input; pulses again every CYCLES clocks while silence lasts
module lpf_watchdog_enable_bit
   import lpf_pkg::*;
#(
   parameter int CYCLES = 10000000
) (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_en,
   input  wire logic i_lvl,
   output logic      o_trip
);
   localparam logic [23:0] LIMIT = 24'(CYCLES - 1);
   lpf_wd_t s_reg;
   lpf_wd_t s_next;
   // ---------------------------------
   // restart on any edge, trip at limit
   // ---------------------------------
   always_comb begin
      s_next      = s_reg;
      s_next.prev = i_lvl;
      s_next.trip = 1'b0;
      if (!i_en || (i_lvl != s_reg.prev)) begin
         s_next.cnt = 24'h000000;
      end else if (s_reg.cnt == LIMIT) begin
         s_next.cnt  = 24'h000000; // rearm: blanks again if still silent
         s_next.trip = 1'b1;
      end else begin
         s_next.cnt = s_reg.cnt + 24'h000001;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
   assign o_trip = s_reg.trip;
endmodule
`default_nettype wire

// *** sim/lpf_host_model.sv ***
`default_nettype none
// ---------------------------------------------
// upstream sender stand-in
// ---------------------------------------------
module lpf_host_model (
   input  wire logic          i_clk,
   output logic               o_seg_start,
   output lpf_pkg::lpf_cmd_e_t o_cmd,
   output logic               o_dv,
   output logic               o_db,
   output logic               o_tv,
   output logic [9:0]         o_tin,
   output logic [2:0]         o_raw
);
   timeunit 1ns;
   timeprecision 1ps;
   import lpf_pkg::*;
   logic quiet;
   // idle values; released lines never hold a stale level
   initial begin
      quiet = 1'b0;
      o_seg_start = 1'b0;
      o_cmd = LPF_CMD_PWM;
      o_dv = 1'b0;
      o_db = 1'b0;
      o_tv = 1'b0;
      o_tin = 10'h000;
      o_raw = 3'h0;
   end
   // clock, data and load lines stay busy unless silence is wanted
   always @(posedge i_clk) begin
      if (!quiet) begin
         o_raw <= ~o_raw;
      end
   end
   // one start, then sixteen bits msb first
   task automatic send16(input lpf_cmd_e_t c, input logic [15:0] d);
      @(posedge i_clk);
      o_seg_start <= 1'b1;
      o_cmd       <= c;
      for (int i = 15; i >= 0; i--) begin
         @(posedge i_clk);
         o_seg_start <= 1'b0;
         o_dv        <= 1'b1;
         o_db        <= d[i];
      end
      @(posedge i_clk);
      o_dv <= 1'b0;
      o_db <= ~d[0];
   endtask
   // sixteen 12-bit values, a for even and b for odd stream slots, msb first
   task automatic send_pwm(input logic [11:0] a, input logic [11:0] b);
      @(posedge i_clk);
      o_seg_start <= 1'b1;
      o_cmd       <= LPF_CMD_PWM;
      for (int i = 191; i >= 0; i--) begin
         @(posedge i_clk);
         o_seg_start <= 1'b0;
         o_dv        <= 1'b1;
         o_db        <= (((191 - i) / 12) % 2 == 1) ? b[i % 12] : a[i % 12];
      end
      @(posedge i_clk);
      o_dv <= 1'b0;
      o_db <= ~b[0];
   endtask
   // tally field passing through, with the command that picks the fault kind
   task automatic tally(input lpf_cmd_e_t c, input logic [9:0] v);
      @(posedge i_clk);
      o_cmd <= c;
      o_tv  <= 1'b1;
      o_tin <= v;
      @(posedge i_clk);
      o_tv  <= 1'b0;
      o_tin <= ~v;
   endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import lpf_pkg::*;
   // ---------------------------------------------
   // stimulus rows and wiring
   // ---------------------------------------------
   typedef struct packed {
      lpf_cmd_e_t  cmd;
      logic [15:0] data;
      logic [7:0]  addr;
      logic [31:0] want;
   } lpf_row_t;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, seg, dv, db, tv, otv, a_n, b_n, hi, lo;
   logic        err, sa, sb, both;
   logic [7:0]  paddr, trim_y, trim_z;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0]  tin, tout;
   logic [15:0] open_led, drive;
   logic [2:0]  raw;
   lpf_cmd_e_t  cmd;
   lpf_row_t    rows [4];
   int          mismatches, num_checks;
   lpf_top #(.PWM_BITS(12), .WATCHDOG_ENABLE_BIT_CYCLES(50)) i_lpf_top (
      .I_CLK(clk), .I_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .I_SEG_START(seg),
      .I_CMD_CODE(cmd), .I_DATA_VALID(dv), .I_DATA_BIT(db), .I_TALLY_VALID(tv), .I_TALLY_IN(tin),
      .O_TALLY_VALID(otv), .O_TALLY_OUT(tout), .I_SERIAL_CLOCK_IN(raw[0]), .I_SERIAL_DATA_IN(raw[1]),
      .I_FRAME_LOAD_IN(raw[2]), .I_OPEN_LED(open_led), .I_TEMP_ABOVE_HI(hi), .I_TEMP_BELOW_LO(lo),
      .O_DRIVE(drive), .O_ANODE_SWITCH_A_N(a_n), .O_ANODE_SWITCH_B_N(b_n),
      .O_PORT_CURRENT_TRIM_Y(trim_y), .O_PORT_CURRENT_TRIM_Z(trim_z));
   lpf_host_model i_lpf_host_model (.i_clk(clk), .o_seg_start(seg), .o_cmd(cmd), .o_dv(dv), .o_db(db),
      .o_tv(tv), .o_tin(tin), .o_raw(raw));
   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      num_checks++;
      if (got !== want) begin
         mismatches++;
         $display("ERROR t=%0t got %h want %h", $time, got, want);
      end
   endtask
   // apb master; bounded wait so a dead slave cannot hang the run
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         mismatches++;
         close_out();
      end
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      {open_led, hi, lo, mismatches, num_checks} = '0;
      rows[0] = '{LPF_CMD_TRIM, 16'h5AC3, 8'h08, 32'h0000C35A};
      rows[1] = '{LPF_CMD_GLOB, 16'h0505, 8'h0C, 32'h00000500};
      rows[2] = '{LPF_CMD_CFG, 16'h0100, 8'h00, 32'h00000000};
      rows[3] = '{LPF_CMD_CFG, 16'h0001, 8'h00, 32'h00000001};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      chk({a_n, b_n, drive}, 32'h30000);
      $display("reset test done");
      foreach (rows[i]) begin
         i_lpf_host_model.send16(rows[i].cmd, rows[i].data);
         apb(1'b0, rows[i].addr, 32'h0);
         chk(rd, rows[i].want);
      end
      chk({trim_y, trim_z}, 32'hC35A);
      $display("command rows done");
      {sa, sb, both} = 3'b000;
      repeat (9000) begin
         @(posedge clk);
         {sa, sb, both} = {sa | ~a_n, sb | ~b_n, both | (~a_n & ~b_n)};
      end
      chk({sa, sb, both}, 32'h6);
      $display("multiplex test done");
      // silence with watchdog off, then on; trip must spare other settings
      i_lpf_host_model.quiet <= 1'b1;
      repeat (80) @(posedge clk);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[1], 32'h0);
      i_lpf_host_model.quiet <= 1'b0;
      apb(1'b1, 8'h00, 32'h3);
      i_lpf_host_model.quiet <= 1'b1;
      repeat (80) @(posedge clk);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd[1], 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'hC35A);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h3);
      i_lpf_host_model.quiet <= 1'b0;
      $display("watchdog test done");
      // fresh pwm data relights; crst brings the origin that applies it
      apb(1'b1, 8'h00, 32'h08);
      i_lpf_host_model.send16(LPF_CMD_GLOB, 16'h7F7F);
      i_lpf_host_model.send_pwm(12'h000, 12'hC00);
      apb(1'b1, 8'h00, 32'h0C);
      repeat (100) @(posedge clk);
      chk(drive, 32'h5555);
      $display("pwm test done");
      // fault tally: kind picked by command low bit
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         open_led <= (k != 1) ? 16'hFFFF : 16'h0000;
         hi       <= (k == 3);
         i_lpf_host_model.tally((k < 2) ? LPF_CMD_TRIM : LPF_CMD_GLOB, 10'h1F0);
         #1;
         chk({otv, tout}, {1'b1, 10'h1F0 + 10'((k == 0) || (k == 3))});
      end
      apb(1'b0, 8'h04, 32'h0);
      chk({rd[0], drive}, 32'h10000);
      hi <= 1'b0;
      lo <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, 8'h04, 32'h0);
      chk({rd[0], drive}, 32'h5555);
      $display("fault test done");
      apb(1'b0, 8'h10, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      $display("unmapped test done");
      close_out();
   end
endmodule
`default_nettype wire
